// [bench/cvp_channel_tb.sv]
// Self-checking bench for the channel value and error policy block
`timescale 1ns/1ns
`default_nettype none
module cvp_channel_tb;
    import cvp_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic tick = 1'b0;
    logic dir = 1'b0;
    logic go = 1'b0;
    logic brk = 1'b0;
    logic shr = 1'b0;
    logic [15:0] freq = 16'h0000;
    logic [7:0] npl = 8'h00;
    logic [15:0] raw;
    logic lb, ls, pul, good;
    logic [31:0] cnt;
    cvp_cfg_type cfg;
    cvp_pv_type pv;
    int n_fail = 0;
    int n_checks = 0;
    cvp_field_model i_field (.mclk_in(mclk_in), .rst_in(rst_in), .freq_in(freq), .brk_in(brk), .shr_in(shr),
        .go_in(go), .n_in(npl), .freq_raw_out(raw), .lead_break_out(lb), .lead_short_out(ls), .pulse_out(pul));
    cvp_channel i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .cycle_tick_in(tick), .cfg_in(cfg), .freq_raw_in(raw),
        .lead_break_in(lb), .lead_short_in(ls), .pulse_in(pul), .dir_in(dir), .pv_out(pv), .count_out(cnt),
        .good_out(good));
    // Clock at 100 MHz
    initial forever #5 mclk_in = ~mclk_in;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One measuring tick, then sample once the result has landed
    task tk;
        @(posedge mclk_in);
        #1 tick = 1'b1;
        @(posedge mclk_in);
        #1 tick = 1'b0;
        @(posedge mclk_in);
        #1;
    endtask : tk
    task burst(input logic [7:0] n);
        npl = n;
        go = 1'b1;
        @(posedge mclk_in);
        #1 go = 1'b0;
        repeat (2 * n + 4) @(posedge mclk_in);
        #1;
    endtask : burst
    task t_scale;
        cfg.range_start = 16'h0064;
        cfg.range_end = 16'h044c;
        cfg.lower_limit = -16'sd50;
        freq = 16'd600;
        tk;
        chk(pv.value, 16'sd500);
        freq = 16'd0;
        tk;
        chk(pv.value, -16'sd50);
        freq = 16'd1100;
        tk;
        chk(pv.value, PCT_FULL);
    endtask : t_scale
    task t_sim;
        cfg.simulate = 1'b1;
        cfg.sim_invalid = 1'b1;
        cfg.sim_value = 16'sd1300;
        tk;
        chk(pv.value, PCT_MAX);
        chk(pv.invalid, 1'b1);
        cfg.sim_value = -16'sd20;
        cfg.sim_invalid = 1'b0;
        tk;
        chk(pv.value, -16'sd20);
        chk(pv.invalid, 1'b0);
        cfg.simulate = 1'b0;
    endtask : t_sim
    task t_policy(input cvp_err_mode_type m, input logic signed [15:0] e);
        cfg.err_mode = m;
        cfg.lead_fault_monitor = 1'b1;
        cfg.good_cycles = 8'h00;
        freq = 16'd600;
        tk;
        freq = 16'd800;
        brk = 1'b1;
        tk;
        chk(pv.value, e);
        chk(pv.line_fault, 1'b1);
        if (m == CVP_ERR_SUBST) chk(pv.invalid, 1'b1);
        brk = 1'b0;
        tk;
        tk;
    endtask : t_policy
    task t_good;
        cfg.good_cycles = 8'h03;
        brk = 1'b1;
        tk;
        chk(good, 1'b0);
        brk = 1'b0;
        tk;
        tk;
        chk(good, 1'b0);
        // Third clean tick releases the fault, the next report shows good
        tk;
        tk;
        chk(good, 1'b1);
        cfg.lead_fault_monitor = 1'b0;
        shr = 1'b1;
        tk;
        chk(pv.line_fault, 1'b0);
        cfg.lead_fault_monitor = 1'b1;
        tk;
        chk(pv.line_fault, 1'b1);
        shr = 1'b0;
        cfg.good_cycles = 8'h00;
        tk;
        tk;
    endtask : t_good
    task t_active;
        cfg.module_active = 1'b0;
        tk;
        chk(pv.active, 1'b0);
        chk(pv.invalid, 1'b1);
        cfg.module_active = 1'b1;
        tk;
        chk(pv.active, 1'b1);
    endtask : t_active
    task t_count;
        cfg.meas = CVP_MEAS_COUNT;
        cfg.quotient = 16'h0003;
        burst(8'd6);
        chk(cnt, 32'h2);
        dir = 1'b1;
        burst(8'd3);
        chk(cnt, 32'h1);
        dir = 1'b0;
        cfg.module_active = 1'b0;
        burst(8'd3);
        chk(cnt, 32'h1);
        cfg.module_active = 1'b1;
    endtask : t_count
    task t_combo;
        cfg.meas = CVP_MEAS_COMBO;
        freq = COMBO_MAX_RAW + 16'h0001;
        tk;
        chk(pv.over_freq, 1'b1);
        freq = COMBO_MAX_RAW;
        tk;
        chk(pv.over_freq, 1'b0);
        // Quotient is ignored in combined mode, every pulse counts
        burst(8'd2);
        chk(cnt, 32'h3);
        // Counter holds still in plain frequency mode
        cfg.meas = CVP_MEAS_FREQ;
        burst(8'd2);
        chk(cnt, 32'h3);
    endtask : t_combo
    task close_out;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        cfg = '0;
        cfg.module_active = 1'b1;
        cfg.quotient = QUOT_ONE;
        cfg.range_end = 16'h03e8;
        repeat (8) @(posedge mclk_in);
        #1 rst_in = 1'b0;
        chk(pv, '0);
        t_scale;
        t_sim;
        cfg.subst_value = 16'sd123;
        t_policy(CVP_ERR_CURRENT, 16'sd700);
        t_policy(CVP_ERR_SUBST, 16'sd123);
        t_policy(CVP_ERR_LAST, 16'sd500);
        t_good;
        t_active;
        t_count;
        t_combo;
        close_out;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #100000;
        n_fail++;
        close_out;
    end
endmodule : cvp_channel_tb
`default_nettype wire

// [bench/cvp_field_model.sv]
// Field-side sensor model: lead status, frequency level and counting pulse train
`timescale 1ns/1ns
`default_nettype none
module cvp_field_model (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [15:0] freq_in,
    input wire logic brk_in,
    input wire logic shr_in,
    input wire logic go_in,
    input wire logic [7:0] n_in,
    output logic [15:0] freq_raw_out,
    output logic lead_break_out,
    output logic lead_short_out,
    output logic pulse_out
);
    logic [7:0] left_q;
    // Sensor levels follow the requested field state
    assign freq_raw_out = freq_in;
    assign lead_break_out = brk_in;
    assign lead_short_out = shr_in;
    // Burst of n one-cycle pulses, one idle cycle between them
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            left_q <= 8'h00;
            pulse_out <= 1'b0;
        end else if (go_in) begin
            left_q <= n_in;
            pulse_out <= 1'b0;
        end else if (left_q != 8'h00 && !pulse_out) begin
            pulse_out <= 1'b1;
            left_q <= left_q - 8'h01;
        end else begin
            pulse_out <= 1'b0;
        end
    end
endmodule : cvp_field_model
`default_nettype wire

// [pkg/cvp_pkg.sv]
// Shared constants and carrier types for the channel value and error policy block
package cvp_pkg;
    // Process value width: signed percent in tenths (-250 .. 1250)
    localparam int VAL_W = 16;
    localparam logic signed [VAL_W-1:0] PCT_MIN = 16'shff06;   // -25.0 %
    localparam logic signed [VAL_W-1:0] PCT_MAX = 16'sh04e2;   // 125.0 %
    localparam logic signed [VAL_W-1:0] PCT_ZERO = 16'sh0000;  // 0 %
    localparam logic signed [VAL_W-1:0] PCT_FULL = 16'sh03e8;  // 100 %
    // Raw measured frequency in units of 0.1 Hz
    localparam int RAW_W = 16;
    localparam int CNT_W = 32;
    localparam int QUOT_W = 16;
    localparam int GOOD_W = 8;
    // Combined counter/frequency ceiling
    localparam int COMBO_MAX_HZ = 50;
    localparam logic [RAW_W-1:0] COMBO_MAX_RAW = 16'h01f4;     // 50.0 Hz in 0.1 Hz
    localparam logic [GOOD_W-1:0] GOOD_RESET = 8'h00;
    localparam logic [QUOT_W-1:0] QUOT_ONE = 16'h0001;

    typedef enum logic [1:0] {
        CVP_ERR_CURRENT = 2'b00,
        CVP_ERR_SUBST = 2'b01,
        CVP_ERR_LAST = 2'b10
    } cvp_err_mode_type;

    typedef enum logic [1:0] {
        CVP_MEAS_FREQ = 2'b00,
        CVP_MEAS_COUNT = 2'b01,
        CVP_MEAS_COMBO = 2'b10
    } cvp_meas_type;

    // Channel configuration
    typedef struct packed {
        logic module_active;
        logic simulate;
        logic sim_invalid;
        cvp_err_mode_type err_mode;
        cvp_meas_type meas;
        logic lead_fault_monitor;
        logic [GOOD_W-1:0] good_cycles;
        logic [QUOT_W-1:0] quotient;
        logic signed [VAL_W-1:0] sim_value;
        logic signed [VAL_W-1:0] subst_value;
        logic [RAW_W-1:0] range_start;
        logic [RAW_W-1:0] range_end;
        logic signed [VAL_W-1:0] lower_limit;
    } cvp_cfg_type;

    // Process value with status
    typedef struct packed {
        logic signed [VAL_W-1:0] value;
        logic invalid;
        logic line_fault;
        logic over_freq;
        logic active;
    } cvp_pv_type;
endpackage : cvp_pkg

// [src/cvp_channel.sv]
// Channel value selection, fault policy, scaling and pulse counting
// Functional notes
// - Normal mode forwards measured value
// - Simulation mode forwards configured simulation value
// - Current policy passes field value despite fault
// - Substitute policy forwards substitute, flagged invalid
// - Hold-last policy keeps last valid value
// - Line fault reported and triggers policy
// - Good only after N clean cycles
// - Channel active follows module activation
// - Combined mode limited to 50 Hz
// - Scale start 0%, end 100%, clamp lower
// - Counter counts every Nth pulse in count mode, every pulse in combined mode
// - Line monitoring disableable per channel
// - Percent values limited to -25..125
`timescale 1ns/1ns
`default_nettype none
module cvp_channel (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cycle_tick_in,
    input wire cvp_pkg::cvp_cfg_type cfg_in,
    input wire logic [cvp_pkg::RAW_W-1:0] freq_raw_in,
    input wire logic lead_break_in,
    input wire logic lead_short_in,
    input wire logic pulse_in,
    input wire logic dir_in,
    output cvp_pkg::cvp_pv_type pv_out,
    output logic [cvp_pkg::CNT_W-1:0] count_out,
    output logic good_out
);
    import cvp_pkg::*;

    logic [GOOD_W-1:0] good_cnt_q;
    logic fault_q;
    logic signed [VAL_W-1:0] last_q;
    logic div_pulse;
    logic fault_now;
    logic over_freq;
    logic signed [VAL_W-1:0] scaled;
    logic signed [VAL_W-1:0] meas_val;
    logic signed [VAL_W-1:0] sel_val;
    logic sel_invalid;
    logic [QUOT_W-1:0] quot_eff;

    assign fault_now = cfg_in.lead_fault_monitor & (lead_break_in | lead_short_in);
    assign over_freq = (cfg_in.meas == CVP_MEAS_COMBO) && (freq_raw_in > COMBO_MAX_RAW);

    function automatic logic signed [VAL_W-1:0] clamp_pct(input logic signed [VAL_W-1:0] v);
        logic signed [VAL_W-1:0] r;
        r = v;
        if (v < PCT_MIN) begin
            r = PCT_MIN;
        end else if (v > PCT_MAX) begin
            r = PCT_MAX;
        end
        return r;
    endfunction : clamp_pct

    // linear scale start->0 %, end->100 %, then lower limit
    always_comb begin
        logic signed [RAW_W+1:0] num;
        logic signed [RAW_W+1:0] span;
        logic signed [RAW_W+12:0] prod;
        logic signed [RAW_W+12:0] q;
        q = '0;
        num = $signed({2'b00, freq_raw_in}) - $signed({2'b00, cfg_in.range_start});
        span = $signed({2'b00, cfg_in.range_end}) - $signed({2'b00, cfg_in.range_start});
        prod = (RAW_W+13)'(num) * (RAW_W+13)'(PCT_FULL);
        if (span > 0) begin
            q = prod / (RAW_W+13)'(span);
        end else begin
            q = '0;
        end
        if (q > (RAW_W+13)'(PCT_MAX)) begin
            q = (RAW_W+13)'(PCT_MAX);
        end else if (q < (RAW_W+13)'(PCT_MIN)) begin
            q = (RAW_W+13)'(PCT_MIN);
        end
        scaled = VAL_W'(q);
        if (scaled < cfg_in.lower_limit) begin
            scaled = cfg_in.lower_limit;
        end
    end

    assign meas_val = scaled;

    // Value selection by mode and error policy
    always_comb begin
        sel_val = meas_val;
        sel_invalid = 1'b0;
        if (cfg_in.simulate) begin
            sel_val = clamp_pct(cfg_in.sim_value);
            sel_invalid = cfg_in.sim_invalid;
        end else if (fault_q) begin
            unique case (cfg_in.err_mode)
                CVP_ERR_CURRENT: sel_val = meas_val;
                CVP_ERR_SUBST: begin
                    sel_val = clamp_pct(cfg_in.subst_value);
                    sel_invalid = 1'b1;
                end
                CVP_ERR_LAST: sel_val = last_q;
                default: sel_val = meas_val;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_q <= 1'b0;
            good_cnt_q <= GOOD_RESET;
        end else if (fault_now) begin
            fault_q <= 1'b1;
            good_cnt_q <= GOOD_RESET;
        end else if (!cfg_in.lead_fault_monitor) begin
            fault_q <= 1'b0;
            good_cnt_q <= GOOD_RESET;
        end else if (cycle_tick_in && fault_q) begin
            if (good_cnt_q + GOOD_W'(1) >= cfg_in.good_cycles) begin
                fault_q <= 1'b0;
                good_cnt_q <= GOOD_RESET;
            end else begin
                good_cnt_q <= good_cnt_q + GOOD_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            last_q <= PCT_ZERO;
        end else if (!fault_now && !fault_q && cycle_tick_in) begin
            last_q <= meas_val;
        end
    end

    // Process value register, updated each measuring cycle
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pv_out <= '0;
            good_out <= 1'b0;
        end else if (cycle_tick_in) begin
            pv_out.active <= cfg_in.module_active;
            pv_out.value <= cfg_in.module_active ? sel_val : PCT_ZERO;
            pv_out.invalid <= sel_invalid | ~cfg_in.module_active;
            pv_out.line_fault <= fault_q | fault_now;
            pv_out.over_freq <= over_freq;
            good_out <= ~(fault_q | fault_now) & cfg_in.module_active;
        end
    end

    // Quotient unused in combined mode
    assign quot_eff = (cfg_in.meas == CVP_MEAS_COUNT) ? cfg_in.quotient : QUOT_ONE;

    cvp_pulse_div #(.W(QUOT_W)) u_div (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .pulse_in(pulse_in & cfg_in.module_active),
        .quotient_in(quot_eff),
        .pulse_out(div_pulse)
    );

    // Up/down counter, direction 1 counts down
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            count_out <= '0;
        end else if (div_pulse && cfg_in.meas != CVP_MEAS_FREQ) begin
            count_out <= dir_in ? count_out - CNT_W'(1) : count_out + CNT_W'(1);
        end
    end

    // Checks
    // substitute implies invalid
    a_subst_invalid: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cycle_tick_in && cfg_in.module_active && !cfg_in.simulate && fault_q
         && cfg_in.err_mode == CVP_ERR_SUBST) |=> pv_out.invalid)
        else $error("substitute not flagged invalid");
    a_sim_value: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cycle_tick_in && cfg_in.module_active && cfg_in.simulate) |=> pv_out.value == $past(sel_val))
        else $error("simulation value not forwarded");
    a_fault_report: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cycle_tick_in && fault_now) |=> pv_out.line_fault && !good_out)
        else $error("line fault not reported");
    a_monitor_off: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!cfg_in.lead_fault_monitor) |=> !fault_q)
        else $error("fault with monitor off");
    a_active_follow: assert property (@(posedge mclk_in) disable iff (rst_in)
        cycle_tick_in |=> pv_out.active == $past(cfg_in.module_active))
        else $error("active does not follow module");
    a_good_delay: assert property (@(posedge mclk_in) disable iff (rst_in)
        (fault_q && !fault_now && cfg_in.lead_fault_monitor && !cycle_tick_in) |=> fault_q)
        else $error("fault cleared without tick");
    a_combo_limit: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cycle_tick_in && over_freq) |=> pv_out.over_freq)
        else $error("over frequency not flagged");
    a_pct_span: assert property (@(posedge mclk_in) disable iff (rst_in)
        (pv_out.value >= PCT_MIN) && (pv_out.value <= PCT_MAX))
        else $error("value outside percent span");
    a_hold_last: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cycle_tick_in && cfg_in.module_active && !cfg_in.simulate && fault_q
         && cfg_in.err_mode == CVP_ERR_LAST) |=> pv_out.value == $past(last_q))
        else $error("last value not held");
    // counter steps only on divided pulse
    a_count_step: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!div_pulse) |=> count_out == $past(count_out))
        else $error("counter moved without pulse");

    c_sim: cover property (@(posedge mclk_in) disable iff (rst_in) cycle_tick_in && cfg_in.simulate);
    c_fault: cover property (@(posedge mclk_in) disable iff (rst_in) fault_q ##1 !fault_q);
    c_subst: cover property (@(posedge mclk_in) disable iff (rst_in) pv_out.invalid && pv_out.line_fault);
    c_count: cover property (@(posedge mclk_in) disable iff (rst_in) div_pulse);
endmodule : cvp_channel
`default_nettype wire

// [src/cvp_pulse_div.sv]
// Pulse prescaler that passes every Nth incoming pulse
`timescale 1ns/1ns
`default_nettype none
module cvp_pulse_div #(
    parameter int W = 16
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic pulse_in,
    input wire logic [W-1:0] quotient_in,
    output logic pulse_out
);
    logic [W-1:0] cnt_q;

    // Count pulses, emit one on the Nth; zero or one divides by one
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= '0;
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= 1'b0;
            if (pulse_in) begin
                if (cnt_q + W'(1) >= quotient_in) begin
                    cnt_q <= '0;
                    pulse_out <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + W'(1);
                end
            end
        end
    end
endmodule : cvp_pulse_div
`default_nettype wire
